// ===== inc/rate_mult_pkg.sv
// Constants and types for the six-bit rate multiplier
package rate_mult_pkg;
   localparam int CNT_W = 6;
   localparam int CNT_PERIOD = 64;
   localparam logic [5:0] CNT_TERMINAL = 6'h3F;
   localparam logic [5:0] CNT_RESET = 6'h00;
   // Register byte addresses
   localparam logic [3:0] CTRL_ADDR = 4'h0;
   localparam logic [3:0] STATUS_ADDR = 4'h4;
   localparam int ADDR_W = 4;
   // Control field positions
   localparam int CTRL_RATE_LSB = 0;
   localparam int CTRL_CLEAR_BIT = 8;
   localparam int CTRL_STROBE_BIT = 9;
   localparam int CTRL_INHIBIT_BIT = 10;
   // Status field positions
   localparam int STAT_COUNT_LSB = 0;
   localparam int STAT_Z_BIT = 8;
   localparam int STAT_Y_BIT = 9;
   localparam int STAT_ENB_BIT = 10;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic inhibit;
      logic strobe;
      logic clear;
      logic [5:0] rate;
   } ctrl_s;

   localparam ctrl_s CTRL_RESET = '{inhibit: 1'b0, strobe: 1'b0,
                                    clear: 1'b0, rate: 6'h00};

   typedef struct packed {
      logic enable_b;
      logic y;
      logic z;
   } pulse_s;

   localparam pulse_s PULSE_RESET = '{enable_b: 1'b1, y: 1'b0, z: 1'b1};
endpackage

// ===== rtl/rate_mult.sv
// Six-bit synchronous binary rate multiplier with AXI4-Lite control
`timescale 1ns/1ps
module rate_mult (
   // Clock, reset, freeze
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // Cascade and control pins, same clock as core_clk_i
   input wire logic enable_b_i,
   input wire logic strobe_i,
   input wire logic clear_i,
   input wire logic unity_i,
   input wire logic [5:0] rate_inputs_i,
   // Pulse outputs: z and enable_b active low, y active high
   output logic y_o,
   output logic z_o,
   output logic enable_b_o,
   // AXI4-Lite slave
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // Lowest zero bit of the count picks the weight that fires this step
   function automatic logic fires(input logic [5:0] cnt,
                                  input logic [5:0] rate);
      logic hit;
      logic [5:0] below;
      hit = 1'b0;
      below = 6'h00;
      // Exactly one position qualifies; count 63 has none
      for (int p = 0; p < rate_mult_pkg::CNT_W; p++) begin
         if (!cnt[p] && ((cnt & below) == below)) begin
            hit = rate[rate_mult_pkg::CNT_W - 1 - p];
         end
         below = {below[4:0], 1'b1};
      end
      return hit;
   endfunction

   rate_mult_pkg::ctrl_s ctrl_ff, nxt_ctrl;
   rate_mult_pkg::pulse_s out_ff, nxt_out;
   logic [5:0] count_ff, nxt_count;
   logic [5:0] rate_eff;
   logic clear_eff, strobe_eff, inhibit_eff, count_en, fire_now;

   logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
   logic [3:0] awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [3:0] wstrb_ff, nxt_wstrb;
   logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0] rdata_ff, nxt_rdata;
   logic aw_take, w_take, ar_take, have_aw, have_w;
   logic [3:0] wr_addr;
   logic [31:0] wr_data, status_word;
   logic [3:0] wr_strb;
   logic [31:0] ctrl_word;

   // Counter and pulse decode
   always_comb begin
      clear_eff = ctrl_ff.clear | clear_i;
      strobe_eff = ctrl_ff.strobe | strobe_i;
      inhibit_eff = ctrl_ff.inhibit | enable_b_i;
      rate_eff = ctrl_ff.rate | rate_inputs_i;
      count_en = !clear_eff && !strobe_eff && !inhibit_eff;
      fire_now = count_en && fires(count_ff, rate_eff);
      nxt_count = count_ff;
      nxt_out = out_ff;
      if (clear_eff) begin
         nxt_count = rate_mult_pkg::CNT_RESET;
      end else if (count_en) begin
         nxt_count = count_ff + 6'h01;
      end
      nxt_out.z = !fire_now;
      // Unity is a sampled level, so a tied clock shows as a constant level
      nxt_out.y = !(nxt_out.z && unity_i);
      nxt_out.enable_b = !(count_en &&
                           count_ff == rate_mult_pkg::CNT_TERMINAL);
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         count_ff <= rate_mult_pkg::CNT_RESET;
         out_ff <= rate_mult_pkg::PULSE_RESET;
      end else if (ce_i) begin
         count_ff <= nxt_count;
         out_ff <= nxt_out;
      end
   end

   assign y_o = out_ff.y;
   assign z_o = out_ff.z;
   assign enable_b_o = out_ff.enable_b;

   // Register slave
   always_comb begin
      aw_take = s_axi_awvalid && !aw_got_ff && !bvalid_ff;
      w_take = s_axi_wvalid && !w_got_ff && !bvalid_ff;
      ar_take = s_axi_arvalid && !rvalid_ff;
      have_aw = aw_got_ff || aw_take;
      have_w = w_got_ff || w_take;
      wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
      wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
      wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
      ctrl_word = 32'h0000_0000;
      ctrl_word[rate_mult_pkg::CTRL_RATE_LSB +: 6] = ctrl_ff.rate;
      ctrl_word[rate_mult_pkg::CTRL_CLEAR_BIT] = ctrl_ff.clear;
      ctrl_word[rate_mult_pkg::CTRL_STROBE_BIT] = ctrl_ff.strobe;
      ctrl_word[rate_mult_pkg::CTRL_INHIBIT_BIT] = ctrl_ff.inhibit;
      status_word = 32'h0000_0000;
      status_word[rate_mult_pkg::STAT_COUNT_LSB +: 6] = count_ff;
      status_word[rate_mult_pkg::STAT_Z_BIT] = out_ff.z;
      status_word[rate_mult_pkg::STAT_Y_BIT] = out_ff.y;
      status_word[rate_mult_pkg::STAT_ENB_BIT] = out_ff.enable_b;
      nxt_ctrl = ctrl_ff;
      nxt_aw_got = aw_got_ff || aw_take;
      nxt_w_got = w_got_ff || w_take;
      nxt_awaddr = aw_take ? s_axi_awaddr : awaddr_ff;
      nxt_wdata = w_take ? s_axi_wdata : wdata_ff;
      nxt_wstrb = w_take ? s_axi_wstrb : wstrb_ff;
      nxt_bvalid = bvalid_ff && !s_axi_bready;
      nxt_bresp = bresp_ff;
      nxt_rvalid = rvalid_ff && !s_axi_rready;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      if (have_aw && have_w && !bvalid_ff) begin
         nxt_aw_got = 1'b0;
         nxt_w_got = 1'b0;
         nxt_bvalid = 1'b1;
         if (wr_addr == rate_mult_pkg::CTRL_ADDR) begin
            nxt_bresp = rate_mult_pkg::RESP_OKAY;
            if (wr_strb[0]) begin
               nxt_ctrl.rate = wr_data[rate_mult_pkg::CTRL_RATE_LSB +: 6];
            end
            if (wr_strb[1]) begin
               nxt_ctrl.clear = wr_data[rate_mult_pkg::CTRL_CLEAR_BIT];
               nxt_ctrl.strobe = wr_data[rate_mult_pkg::CTRL_STROBE_BIT];
               nxt_ctrl.inhibit = wr_data[rate_mult_pkg::CTRL_INHIBIT_BIT];
            end
         end else begin
            nxt_bresp = rate_mult_pkg::RESP_SLVERR;
         end
      end
      if (ar_take) begin
         nxt_rvalid = 1'b1;
         nxt_rresp = rate_mult_pkg::RESP_OKAY;
         case (s_axi_araddr)
            rate_mult_pkg::CTRL_ADDR: nxt_rdata = ctrl_word;
            rate_mult_pkg::STATUS_ADDR: nxt_rdata = status_word;
            default: begin
               nxt_rdata = 32'h0000_0000;
               nxt_rresp = rate_mult_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         ctrl_ff <= rate_mult_pkg::CTRL_RESET;
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
         rvalid_ff <= 1'b0;
         rresp_ff <= 2'h0;
         rdata_ff <= 32'h0000_0000;
      end else if (ce_i) begin
         ctrl_ff <= nxt_ctrl;
         aw_got_ff <= nxt_aw_got;
         w_got_ff <= nxt_w_got;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         wstrb_ff <= nxt_wstrb;
         bvalid_ff <= nxt_bvalid;
         bresp_ff <= nxt_bresp;
         rvalid_ff <= nxt_rvalid;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
      end
   end

   // Ready gated by ce so nothing is taken while frozen
   assign s_axi_awready = !aw_got_ff && !bvalid_ff && ce_i;
   assign s_axi_wready = !w_got_ff && !bvalid_ff && ce_i;
   assign s_axi_arready = !rvalid_ff && ce_i;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_clear_all;
      ce_i && clear_eff && strobe_eff && unity_i;
   endsequence

   sequence s_clear_seen;
      count_ff == 6'h00 && !out_ff.y && out_ff.enable_b;
   endsequence

   chk_count_hold: assert property (
      ce_i && !count_en && !clear_eff |=> $stable(count_ff))
      else $error("counter moved while not enabled");
   chk_count_step: assert property (
      ce_i && count_en |=> count_ff == $past(count_ff) + 6'h01)
      else $error("counter did not advance by one");
   chk_pulse_fire: assert property (
      ce_i && fire_now |=> !out_ff.z)
      else $error("rate pulse missing on ungated output");
   chk_rate_zero: assert property (
      ce_i && rate_eff == 6'h00 |=> out_ff.z)
      else $error("ungated output pulsed with zero rate");
   chk_strobe_block: assert property (
      ce_i && strobe_eff |=> out_ff.z)
      else $error("pulse passed while strobe high");
   chk_unity_pass: assert property (
      ce_i && strobe_eff && unity_i |=> !out_ff.y)
      else $error("gated output not inverse of unity");
   chk_unity_low: assert property (
      ce_i && !unity_i |=> out_ff.y)
      else $error("gated output not forced high");
   chk_clear_state: assert property (
      s_clear_all |=> s_clear_seen)
      else $error("clear did not reset counter and outputs");
   chk_term_pulse: assert property (
      ce_i && count_en && count_ff == 6'h3F |=> !out_ff.enable_b
      ##0 count_ff == 6'h00)
      else $error("terminal enable pulse missing");
endmodule

// ===== tb/rate_source.sv
// Model of the pin-side logic feeding one multiplier stage
`timescale 1ns/1ps
module rate_source (
   // Clock and settings
   input wire logic core_clk_i,
   input wire logic [9:0] set_i,
   // Stage pins
   output logic unity_o,
   output logic clear_o,
   output logic strobe_o,
   output logic enable_b_o,
   output logic [5:0] rate_o
);
   // Registered, so pins only move just after an edge
   always_ff @(posedge core_clk_i) begin
      {unity_o, clear_o, strobe_o, enable_b_o, rate_o} <= set_i;
   end
endmodule

// ===== tb/test_six_bit_rate_multiplier.sv
// Self-checking bench for the six-bit rate multiplier
`timescale 1ns/1ps
module test_six_bit_rate_multiplier;
   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [9:0] setv = 10'h340;
   logic unity, clr, stb, enb, y_o, z_o, enable_b_o;
   logic [5:0] rate;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
   logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [5:0] rates [9] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
                             6'h20, 6'h3F, 6'h28};
   logic [3:0] holds [2] = '{4'hA, 4'h9};
   int miscompares = 0;
   int checked = 0;
   int zc, yc, ec;
   logic ce = 1'b1;
   event abort_ev;
   initial forever #25 core_clk_i = ~core_clk_i;
   rate_source src (.core_clk_i, .set_i(setv), .unity_o(unity),
      .clear_o(clr), .strobe_o(stb), .enable_b_o(enb), .rate_o(rate));
   // Byte strobes tied: every access is a full word
   rate_mult dut (.core_clk_i, .rst_b_i, .ce_i(ce), .enable_b_i(enb),
      .strobe_i(stb), .clear_i(clr), .unity_i(unity), .rate_inputs_i(rate),
      .y_o, .z_o, .enable_b_o, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic hang(input logic ok);
      if (!ok) begin
         cmp("bus answer", 32'h1, 32'h0);
         -> abort_ev;
      end
   endtask
   initial begin
      @(abort_ev);
      final_report();
   end
   // Handshakes sampled at the falling edge, the level the next rise sees
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int i;
      logic aw_hit, w_hit, b_hit;
      b_hit = 1'b0;
      @(posedge core_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40 && !b_hit; i++) begin
         @(negedge core_clk_i);
         aw_hit = s_axi_awvalid && s_axi_awready;
         w_hit = s_axi_wvalid && s_axi_wready;
         b_hit = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge core_clk_i);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      hang(b_hit);
   endtask
   task automatic rdr(input logic [3:0] a);
      int i;
      logic ar_hit, r_hit;
      r_hit = 1'b0;
      @(posedge core_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40 && !r_hit; i++) begin
         @(negedge core_clk_i);
         ar_hit = s_axi_arvalid && s_axi_arready;
         r_hit = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge core_clk_i);
         if (ar_hit) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      hang(r_hit);
   endtask
   task automatic pins(input logic [9:0] v);
      @(posedge core_clk_i);
      setv <= v;
   endtask
   // Any 64 consecutive running cycles hold one full count cycle
   task automatic meas(input logic [9:0] v);
      pins(v);
      zc = 0;
      yc = 0;
      ec = 0;
      repeat (3) @(posedge core_clk_i);
      repeat (64) begin
         @(negedge core_clk_i);
         zc = zc + int'(z_o === 1'b0);
         yc = yc + int'(y_o === 1'b1);
         ec = ec + int'(enable_b_o === 1'b0);
      end
   endtask
   initial begin
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rdr(rate_mult_pkg::CTRL_ADDR);
      cmp("ctrl reset", 32'h0, rd);
      rdr(rate_mult_pkg::STATUS_ADDR);
      cmp("status reset", 32'h500, rd);
      $display("reset test done");
      foreach (rates[k]) begin
         meas({4'h8, rates[k]});
         cmp("z pulses", 32'(rates[k]), zc);
         cmp("y pulses", 32'(rates[k]), yc);
         cmp("enable pulses", 32'h1, ec);
      end
      meas({4'h0, 6'h3F});
      cmp("y gated", 32'd64, yc);
      cmp("z ungated", 32'd63, zc);
      $display("rate test done");
      foreach (holds[k]) begin
         meas({holds[k], 6'h20});
         cmp("held enable", 32'h0, ec);
         if (k == 0) cmp("strobed z", 32'h0, zc);
         if (k == 0) cmp("strobed y", 32'h0, yc);
         rdr(rate_mult_pkg::STATUS_ADDR);
         zc = int'(rd[5:0]);
         rdr(rate_mult_pkg::STATUS_ADDR);
         cmp("frozen count", 32'(zc), {26'h0, rd[5:0]});
      end
      meas({4'hE, 6'h3F});
      cmp("clear y", 32'h0, yc);
      cmp("clear enable", 32'h0, ec);
      pins({4'h8, 6'h00});
      repeat (4) @(posedge core_clk_i);
      pins({4'h9, 6'h00});
      repeat (3) @(posedge core_clk_i);
      rdr(rate_mult_pkg::STATUS_ADDR);
      cmp("edge count", 32'h5, {26'h0, rd[5:0]});
      // Enabled pins while frozen must leave the count alone
      @(posedge core_clk_i);
      ce <= 1'b0;
      pins({4'h8, 6'h00});
      repeat (4) @(posedge core_clk_i);
      pins({4'h9, 6'h00});
      repeat (3) @(posedge core_clk_i);
      ce <= 1'b1;
      rdr(rate_mult_pkg::STATUS_ADDR);
      cmp("ce frozen count", 32'h5, {26'h0, rd[5:0]});
      $display("hold test done");
      wr(rate_mult_pkg::CTRL_ADDR, 32'h8);
      cmp("ctrl write", 32'(rate_mult_pkg::RESP_OKAY), 32'(rs));
      meas({4'h8, 6'h00});
      cmp("register rate", 32'h8, zc);
      rdr(rate_mult_pkg::CTRL_ADDR);
      cmp("ctrl read", 32'h8, rd);
      wr(rate_mult_pkg::STATUS_ADDR, 32'h0);
      cmp("ro write", 32'(rate_mult_pkg::RESP_SLVERR), 32'(rs));
      rdr(4'h8);
      cmp("unmapped resp", 32'(rate_mult_pkg::RESP_SLVERR), 32'(rs));
      cmp("unmapped data", 32'h0, rd);
      $display("bus test done");
      final_report();
   end
endmodule
